// ===== core/usw_ctrl.sv
`timescale 1ns/1ns
module usw_fifo #(parameter int W = 8, parameter int D = 8)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } usw_fifo_st_s;
  usw_fifo_st_s r;
  usw_fifo_st_s n;
  logic push;
  logic pop;

  // Flags come straight from the fill count
  assign in_ready_out = (r.cnt != (AW+1)'(D));
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out = r.mem[r.rp];

  // Pointer and storage update
  always_comb
  begin
    n = r;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    if (push)
    begin
      n.mem[r.wp] = in_data_in;
      n.wp = r.wp + 1'b1;
    end
    if (pop)
      n.rp = r.rp + 1'b1;
    n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      r <= '0;
    else
      r <= n;
  end
endmodule

module usw_ctrl
(
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [9:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Timer compare match, same clock
  input wire logic TIMER_MATCH_IN,
  // Serial data pin
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N_OUT,
  output logic SDA_PU_OUT,
  // Shift clock pin
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_N_OUT,
  output logic SCL_PU_OUT,
  // Data output pin
  output logic DO_OUT,
  output logic DO_OE_N_OUT,
  output logic DO_PU_OUT,
  // Interrupt requests
  output logic START_IRQ_OUT,
  output logic OVF_IRQ_OUT
);
  usw_pkg::usw_state_s r;
  usw_pkg::usw_state_s n;
  logic sda;
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic acc;
  logic commit;
  logic [7:0] idx;
  logic hit;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic wr_port;
  logic rd_buf;
  logic [7:0] wd;
  logic two;
  logic [1:0] wm;
  logic [1:0] cs;
  logic sh_en;
  logic cnt_en;
  logic ovf_ev;
  logic start_ev;
  logic hold;
  logic f_ready;
  logic f_valid;
  logic [7:0] f_data;

  // Receive buffer filled on each counter wrap
  usw_fifo #(.W(usw_pkg::FIFO_W), .D(usw_pkg::FIFO_D)) u_fifo
  (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .in_valid_in(ovf_ev),
    .in_ready_out(f_ready),
    .in_data_in(n.shreg),
    .out_valid_out(f_valid),
    .out_ready_in(rd_buf),
    .out_data_out(f_data)
  );

  // Bus decode; a write lands on the edge that sees pready
  assign acc = PSEL_IN && PENABLE_IN;
  assign commit = acc && r.pready;
  assign idx = PADDR_IN[9:2];
  assign wd = PWDATA_IN[7:0];
  assign hit = (PADDR_IN[1:0] == 2'h0) && idx >= usw_pkg::IDX_CTRL &&
               idx <= usw_pkg::IDX_BUF;
  assign wr_ctrl = commit && PWRITE_IN && idx == usw_pkg::IDX_CTRL &&
                   PADDR_IN[1:0] == 2'h0;
  assign wr_stat = commit && PWRITE_IN && idx == usw_pkg::IDX_STAT &&
                   PADDR_IN[1:0] == 2'h0;
  assign wr_data = commit && PWRITE_IN && idx == usw_pkg::IDX_DATA &&
                   PADDR_IN[1:0] == 2'h0;
  assign wr_port = commit && PWRITE_IN && idx == usw_pkg::IDX_PORT &&
                   PADDR_IN[1:0] == 2'h0;
  assign rd_buf = commit && !PWRITE_IN && idx == usw_pkg::IDX_BUF &&
                  PADDR_IN[1:0] == 2'h0;

  // Synchronised pin levels and their edges
  assign sda = r.sda_sy[1];
  assign scl = r.scl_sy[1];
  assign scl_rise = scl && !r.scl_d;
  assign scl_fall = !scl && r.scl_d;
  assign wm = r.ctrl[5:4];
  assign two = wm[1];
  assign cs = r.ctrl[3:2];

  // Clock source selection; a wrap with a full buffer stalls the shift
  always_comb
  begin
    sh_en = 1'b0;
    cnt_en = 1'b0;
    case (cs)
      usw_pkg::CS_SOFT:
      begin
        sh_en = wr_ctrl && wd[usw_pkg::CTRL_CLK];
        cnt_en = sh_en;
      end
      usw_pkg::CS_TIMER:
      begin
        sh_en = TIMER_MATCH_IN;
        cnt_en = TIMER_MATCH_IN;
      end
      default:
      begin
        sh_en = (cs == usw_pkg::CS_EXT_POS) ? scl_rise : scl_fall;
        cnt_en = r.ctrl[usw_pkg::CTRL_CLK] ?
                 (wr_ctrl && wd[usw_pkg::CTRL_TC]) : (scl_rise || scl_fall);
      end
    endcase
    if (cnt_en && r.cnt == usw_pkg::CNT_MAX && !f_ready)
    begin
      sh_en = 1'b0;
      cnt_en = 1'b0;
    end
  end

  assign ovf_ev = cnt_en && r.cnt == usw_pkg::CNT_MAX;
  // Start condition in two-wire mode, otherwise an external pin clock edge with the strobe bit clear
  assign start_ev = two ? (!sda && r.sda_d && scl) :
                    (cs[1] && !r.ctrl[usw_pkg::CTRL_CLK] &&
                     (scl_rise || scl_fall));

  // Next state: sync, bus, shifter, flags, pins, interrupts
  always_comb
  begin
    n = r;
    hold = 1'b0;
    n.sda_sy = {r.sda_sy[0], SDA_IN};
    n.scl_sy = {r.scl_sy[0], SCL_IN};
    n.sda_d = sda;
    n.scl_d = scl;
    n.pready = acc && !r.pready;
    n.pslverr = acc && !r.pready && !hit;
    n.prdata = '0;
    if (acc && !r.pready)
    begin
      case (idx)
        usw_pkg::IDX_CTRL: n.prdata[7:0] = {r.ctrl[7:2], 2'h0};
        usw_pkg::IDX_STAT:
          n.prdata[7:0] = {r.start_flag, r.ovf_flag, 2'h0, r.cnt};
        usw_pkg::IDX_DATA: n.prdata[7:0] = r.shreg;
        usw_pkg::IDX_PORT: n.prdata[7:0] = r.portr;
        usw_pkg::IDX_BUF: n.prdata[7:0] = f_valid ? f_data : 8'h00;
        default: n.prdata = '0;
      endcase
    end
    if (wr_ctrl)
      n.ctrl = {wd[7:1], 1'b0};
    if (wr_port)
      n.portr = wd & usw_pkg::PORT_MASK;
    if (wr_ctrl && wd[usw_pkg::CTRL_TC])
      n.portr[usw_pkg::PIN_CK] = !r.portr[usw_pkg::PIN_CK];
    // Shifter and counter; a bus write wins over a clock
    if (sh_en)
      n.shreg = {r.shreg[6:0], sda};
    if (wr_data)
      n.shreg = wd;
    if (cnt_en)
      n.cnt = r.cnt + 4'h1;
    if (wr_stat)
      n.cnt = wd[3:0];
    // Flags: write one clears, a same-cycle event wins
    if (wr_stat && wd[usw_pkg::STAT_SIF])
      n.start_flag = 1'b0;
    if (start_ev)
      n.start_flag = 1'b1;
    if (wr_stat && wd[usw_pkg::STAT_OIF])
      n.ovf_flag = 1'b0;
    if (ovf_ev)
      n.ovf_flag = 1'b1;
    // Pins follow the port unless a serial mode takes them
    n.do_p.o = n.portr[usw_pkg::PIN_DO];
    n.do_p.oe_n = !n.portr[usw_pkg::PIN_DO + usw_pkg::DDR_OFS];
    n.do_p.pu = n.do_p.oe_n && n.portr[usw_pkg::PIN_DO];
    n.sda_p.o = n.portr[usw_pkg::PIN_SD];
    n.sda_p.oe_n = !n.portr[usw_pkg::PIN_SD + usw_pkg::DDR_OFS];
    n.sda_p.pu = n.sda_p.oe_n && n.portr[usw_pkg::PIN_SD];
    n.scl_p.o = n.portr[usw_pkg::PIN_CK];
    n.scl_p.oe_n = !n.portr[usw_pkg::PIN_CK + usw_pkg::DDR_OFS];
    n.scl_p.pu = n.scl_p.oe_n && n.portr[usw_pkg::PIN_CK];
    if (n.ctrl[5:4] == usw_pkg::WM_THREE)
      n.do_p.o = n.shreg[7];
    if (n.ctrl[5])
    begin
      hold = n.start_flag || (n.ctrl[5:4] == usw_pkg::WM_TWO_HOLD &&
             n.ovf_flag);
      n.sda_p.o = 1'b0;
      n.sda_p.oe_n = !(n.portr[usw_pkg::PIN_SD + usw_pkg::DDR_OFS] &&
                     (!n.shreg[7] || !n.portr[usw_pkg::PIN_SD]));
      n.sda_p.pu = 1'b0;
      n.scl_p.o = 1'b0;
      n.scl_p.oe_n = !(n.portr[usw_pkg::PIN_CK + usw_pkg::DDR_OFS] &&
                     (!n.portr[usw_pkg::PIN_CK] || hold));
      n.scl_p.pu = 1'b0;
    end
    // Requests follow flag, enable and global enable every cycle
    n.sirq = n.start_flag && n.ctrl[usw_pkg::CTRL_SIE] &&
             n.portr[usw_pkg::PORT_GIE];
    n.oirq = n.ovf_flag && n.ctrl[usw_pkg::CTRL_OIE] &&
             n.portr[usw_pkg::PORT_GIE];
  end

  // State register
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      r <= usw_pkg::RST_ST;
    else
      r <= n;
  end

  // Outputs straight from the state register
  assign PRDATA_OUT = r.prdata;
  assign PREADY_OUT = r.pready;
  assign PSLVERR_OUT = r.pslverr;
  assign SDA_OUT = r.sda_p.o;
  assign SDA_OE_N_OUT = r.sda_p.oe_n;
  assign SDA_PU_OUT = r.sda_p.pu;
  assign SCL_OUT = r.scl_p.o;
  assign SCL_OE_N_OUT = r.scl_p.oe_n;
  assign SCL_PU_OUT = r.scl_p.pu;
  assign DO_OUT = r.do_p.o;
  assign DO_OE_N_OUT = r.do_p.oe_n;
  assign DO_PU_OUT = r.do_p.pu;
  assign START_IRQ_OUT = r.sirq;
  assign OVF_IRQ_OUT = r.oirq;

  // Checks on the registered behaviour
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence s_wrap;
    r.cnt == 4'hf ##1 (r.cnt == 4'h0 && !$past(wr_stat));
  endsequence
  sequence s_toggle;
    wr_ctrl && wd[0] && !wr_port;
  endsequence

  a_start_irq: assert property (START_IRQ_OUT ==
    (r.start_flag && r.ctrl[7] && r.portr[7]))
    else $error("start request does not follow flag and enables");
  a_ovf_irq: assert property (OVF_IRQ_OUT ==
    (r.ovf_flag && r.ctrl[6] && r.portr[7]))
    else $error("overflow request does not follow flag and enables");
  a_pending_irq: assert property ((r.start_flag && wr_ctrl &&
    wd[7] && r.portr[7] && !wr_stat) |=> START_IRQ_OUT)
    else $error("pending start flag not raised at once");
  a_ovf_wrap: assert property (s_wrap |-> r.ovf_flag)
    else $error("overflow flag not set on wrap");
  a_start_sticky: assert property ((r.start_flag &&
    !(wr_stat && wd[7])) |=> r.start_flag)
    else $error("start flag dropped without a clear");
  a_scl_start: assert property ((r.ctrl[5] && r.start_flag &&
    r.portr[5]) |-> (!SCL_OE_N_OUT && !SCL_OUT))
    else $error("SCL not held after start");
  a_scl_ovf: assert property ((r.ctrl[5:4] == 2'h3 &&
    r.ovf_flag && r.portr[5]) |-> !SCL_OE_N_OUT)
    else $error("SCL not held after overflow");
  a_sda_drive: assert property (r.ctrl[5] |-> (SDA_OE_N_OUT ==
    !(r.portr[4] && (!r.shreg[7] || !r.portr[1])) && !SDA_OUT))
    else $error("SDA drive wrong in two-wire mode");
  a_scl_port: assert property ((r.ctrl[5] && !r.start_flag &&
    r.ctrl[4] == 1'b0) |-> (SCL_OE_N_OUT == !(r.portr[5] && !r.portr[2])))
    else $error("SCL drive wrong in two-wire mode");
  a_off_port: assert property (r.ctrl[5:4] == 2'h0 |->
    (DO_OUT == r.portr[0] && SCL_OUT == r.portr[2] &&
     SDA_OE_N_OUT == !r.portr[4]))
    else $error("pins not under port control");
  a_do_three: assert property (r.ctrl[5:4] == 2'h1 |->
    (DO_OUT == r.shreg[7] && DO_OE_N_OUT == !r.portr[3]))
    else $error("data output not from shift register");
  a_pu_two: assert property (r.ctrl[5] |->
    (!SDA_PU_OUT && !SCL_PU_OUT))
    else $error("pull-up active in two-wire mode");
  a_toggle_ck: assert property (s_toggle |=>
    r.portr[2] != $past(r.portr[2]))
    else $error("toggle strobe did not invert clock port");
endmodule

// ===== core/usw_pkg.sv
// Function
// - Start enable lets start flag raise interrupt
// - Overflow enable lets overflow flag raise interrupt
// - Pending flag interrupts at once when enabled
// - Wire mode changes outputs only, never inputs
// - Mode zero leaves pins under port control
// - Three-wire: shift output replaces port data bit
// - Three-wire: input and clock pins stay normal
// - Two-wire: open-collector, drivers enabled by direction
// - SDA low when shift bit or port low
// - SCL low when port low or hold
// - Start detection holds SCL until flag cleared
// - Two-wire disables pull-ups, inputs keep working
// - Mode three also holds SCL on overflow
// - Overflow flag set on wrap, cleared by one
// - Start flag sticky until one is written
// - Three-wire: data output taken from shift register bit seven
// - Toggle strobe inverts clock port bit always
package usw_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h0d;
  localparam logic [7:0] IDX_STAT = 8'h0e;
  localparam logic [7:0] IDX_DATA = 8'h0f;
  localparam logic [7:0] IDX_PORT = 8'h10;
  localparam logic [7:0] IDX_BUF = 8'h11;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // Control register fields
  localparam int CTRL_SIE = 7;
  localparam int CTRL_OIE = 6;
  localparam int CTRL_CLK = 1;
  localparam int CTRL_TC = 0;
  // Status register fields
  localparam int STAT_SIF = 7;
  localparam int STAT_OIF = 6;
  // Port register fields: port bits 2:0, direction bits 5:3
  localparam int PORT_GIE = 7;
  localparam int PIN_DO = 0;
  localparam int PIN_SD = 1;
  localparam int PIN_CK = 2;
  localparam int DDR_OFS = 3;
  localparam logic [7:0] PORT_MASK = 8'hbf;
  // Wire modes and clock sources
  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;
  localparam logic [1:0] CS_SOFT = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [1:0] CS_EXT_POS = 2'h2;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;

  // One pin's drive: level, active-low enable, pull-up
  typedef struct packed {
    logic o;
    logic oe_n;
    logic pu;
  } usw_pin_s;

  // Whole state of the control block
  typedef struct packed {
    logic [7:0] ctrl;
    logic start_flag;
    logic ovf_flag;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] portr;
    logic [1:0] sda_sy;
    logic [1:0] scl_sy;
    logic sda_d;
    logic scl_d;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    usw_pin_s do_p;
    usw_pin_s sda_p;
    usw_pin_s scl_p;
    logic sirq;
    logic oirq;
  } usw_state_s;

  // Reset image: every pin released, line samples at their idle high level
  localparam usw_state_s RST_ST = '{
    sda_sy: 2'h3,
    scl_sy: 2'h3,
    sda_d: 1'b1,
    scl_d: 1'b1,
    do_p: '{o: 1'b0, oe_n: 1'b1, pu: 1'b0},
    sda_p: '{o: 1'b0, oe_n: 1'b1, pu: 1'b0},
    scl_p: '{o: 1'b0, oe_n: 1'b1, pu: 1'b0},
    default: '0
  };
endpackage

// ===== verification/usw_peer.sv
`timescale 1ns/1ns
// Serial bus peer: open-drain master making start, stop and clock pulses
module usw_peer
(
  // Device drive
  input wire logic sda_o_in,
  input wire logic sda_oe_n_in,
  input wire logic scl_o_in,
  input wire logic scl_oe_n_in,
  // Resolved line levels
  output logic sda_out,
  output logic scl_out
);
  logic sda_rel = 1'b1;
  logic scl_rel = 1'b1;
  // Lines pulled up; whichever party drives low wins
  assign sda_out = (sda_oe_n_in ? 1'b1 : sda_o_in) & sda_rel;
  assign scl_out = (scl_oe_n_in ? 1'b1 : scl_o_in) & scl_rel;
  // Data falls while clock high, then the clock is pulled low and let go
  task automatic start_cond();
    sda_rel = 1'b0;
    #250;
    scl_rel = 1'b0;
    #250;
    scl_rel = 1'b1;
  endtask
  // Data rises while clock high
  task automatic stop_cond();
    #250;
    sda_rel = 1'b1;
    #250;
  endtask
  // Clock pulses at 125 ns, standing high outside the frame
  task automatic pulses(input int n);
    repeat (n)
    begin
      scl_rel = 1'b0;
      #63;
      scl_rel = 1'b1;
      #62;
    end
  endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] RC = usw_pkg::IDX_CTRL;
  localparam logic [7:0] RS = usw_pkg::IDX_STAT;
  localparam logic [7:0] RD = usw_pkg::IDX_DATA;
  localparam logic [7:0] RP = usw_pkg::IDX_PORT;
  localparam logic [7:0] RB = usw_pkg::IDX_BUF;
  logic clk, rst_n, psel, penable, pwrite, tmatch;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sda_in, scl_in, sda_o, sda_oe_n, sda_pu;
  logic scl_o, scl_oe_n, scl_pu, do_o, do_oe_n, do_pu, s_irq, o_irq;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  usw_ctrl u_usw_ctrl (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TIMER_MATCH_IN(tmatch),
    .SDA_IN(sda_in), .SDA_OUT(sda_o), .SDA_OE_N_OUT(sda_oe_n),
    .SDA_PU_OUT(sda_pu), .SCL_IN(scl_in), .SCL_OUT(scl_o),
    .SCL_OE_N_OUT(scl_oe_n), .SCL_PU_OUT(scl_pu), .DO_OUT(do_o),
    .DO_OE_N_OUT(do_oe_n), .DO_PU_OUT(do_pu), .START_IRQ_OUT(s_irq),
    .OVF_IRQ_OUT(o_irq));
  usw_peer u_usw_peer (.sda_o_in(sda_o), .sda_oe_n_in(sda_oe_n),
    .scl_o_in(scl_o), .scl_oe_n_in(scl_oe_n), .sda_out(sda_in),
    .scl_out(scl_in));
  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  // Counts and verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compare one value
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [7:0] wd, output logic [31:0] d, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    // Look mid-cycle at what stands at the coming rising edge
    @(negedge clk);
    while (pready !== 1'b1) @(negedge clk);
    d = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, v, d, e);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    logic e;
    apb(1'b0, idx, 8'h00, d, e);
  endtask
  // Let registered pins follow
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Reset values, access kinds and a refused address
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    rd(RC, d);
    check("ctrl reset", d, 32'h0);
    check("scl oe_n reset", 32'(scl_oe_n), 32'h1);
    wr(RC, 8'hff);
    rd(RC, d);
    check("ctrl rw", d, 32'hfc);
    wr(RC, 8'h00);
    apb(1'b0, 8'h20, 8'h00, d, e);
    check("unmapped err", 32'(e), 32'h1);
    check("unmapped data", d, 32'h0);
  endtask
  // Mode zero: pins under port control, no start detection
  task automatic t_mode0();
    logic [31:0] d;
    wr(RP, 8'h24);
    settle();
    check("m0 scl oe_n", 32'(scl_oe_n), 32'h0);
    check("m0 scl", 32'(scl_o), 32'h1);
    wr(RP, 8'h04);
    settle();
    check("m0 scl pu", 32'(scl_pu), 32'h1);
    u_usw_peer.start_cond();
    u_usw_peer.stop_cond();
    settle();
    rd(RS, d);
    check("m0 no start", d, 32'h01);
  endtask
  // Three-wire: shift MSB replaces the port data bit
  task automatic t_three();
    wr(RC, 8'h10);
    wr(RP, 8'h08);
    wr(RD, 8'h80);
    settle();
    check("do oe_n", 32'(do_oe_n), 32'h0);
    check("do msb", 32'(do_o), 32'h1);
    wr(RD, 8'h7f);
    settle();
    check("do msb low", 32'(do_o), 32'h0);
    wr(RP, 8'h01);
    settle();
    check("do input", 32'(do_oe_n), 32'h1);
    check("do pu", 32'(do_pu), 32'h1);
    check("ck normal", 32'(scl_oe_n), 32'h1);
  endtask
  // Strobed wraps fill the buffer until it refuses, then drain it
  task automatic t_fifo();
    logic [31:0] d;
    wr(RP, 8'h00);
    wr(RD, 8'hff);
    for (int i = 0; i < 9; i++)
    begin
      wr(RS, 8'h0f);
      wr(RC, 8'h12);
      if (i == 0)
      begin
        rd(RS, d);
        check("wrap flag", d, 32'h40);
      end
    end
    for (int i = 0; i < 9; i++)
    begin
      rd(RB, d);
      check("buffer", d, (i < 8) ? 32'hff : 32'h0);
    end
  endtask
  // Pending overflow raises its request once enabled
  task automatic t_irq();
    logic [31:0] d;
    check("irq off", 32'(o_irq), 32'h0);
    wr(RC, 8'h50);
    settle();
    check("irq no gie", 32'(o_irq), 32'h0);
    wr(RP, 8'h80);
    settle();
    check("irq pending", 32'(o_irq), 32'h1);
    check("start irq", 32'(s_irq), 32'h0);
    wr(RS, 8'h40);
    settle();
    check("irq cleared", 32'(o_irq), 32'h0);
    rd(RS, d);
    check("ovf w1c", d, 32'h0);
  endtask
  // Two-wire: start hold, open-drain drive, no pull-ups
  task automatic t_two();
    logic [31:0] d;
    wr(RD, 8'hff);
    wr(RC, 8'h20);
    wr(RP, 8'hb6);
    settle();
    check("scl released", 32'(scl_oe_n), 32'h1);
    check("sda pu", 32'(sda_pu), 32'h0);
    check("scl pu", 32'(scl_pu), 32'h0);
    u_usw_peer.start_cond();
    settle();
    check("start hold", 32'(scl_oe_n), 32'h0);
    check("hold low", 32'(scl_o), 32'h0);
    check("start irq masked", 32'(s_irq), 32'h0);
    wr(RC, 8'ha0);
    settle();
    check("start irq", 32'(s_irq), 32'h1);
    repeat (50) @(posedge clk);
    rd(RS, d);
    check("start sticky", 32'(d[7]), 32'h1);
    wr(RS, 8'h80);
    settle();
    check("hold freed", 32'(scl_oe_n), 32'h1);
    check("start irq off", 32'(s_irq), 32'h0);
    u_usw_peer.stop_cond();
    wr(RP, 8'hb2);
    settle();
    check("scl port low", 32'(scl_oe_n), 32'h0);
    wr(RD, 8'h00);
    settle();
    check("sda msb low", 32'(sda_oe_n), 32'h0);
    check("sda level", 32'(sda_o), 32'h0);
    wr(RD, 8'hff);
    wr(RP, 8'hb0);
    settle();
    check("sda port low", 32'(sda_oe_n), 32'h0);
    wr(RP, 8'hb2);
    settle();
    check("sda released", 32'(sda_oe_n), 32'h1);
  endtask
  // Overflow holds the clock only in mode three
  task automatic t_hold();
    wr(RP, 8'hb6);
    wr(RS, 8'h0f);
    wr(RC, 8'h22);
    settle();
    check("two no hold", 32'(scl_oe_n), 32'h1);
    wr(RS, 8'h4f);
    wr(RC, 8'h32);
    settle();
    check("ovf hold", 32'(scl_oe_n), 32'h0);
    wr(RS, 8'h40);
    settle();
    check("ovf freed", 32'(scl_oe_n), 32'h1);
  endtask
  // Toggle strobe, external clock in mode zero, timer source
  task automatic t_clocks();
    logic [31:0] d;
    wr(RP, 8'h00);
    wr(RC, 8'h01);
    rd(RP, d);
    check("toggle up", d, 32'h04);
    wr(RC, 8'h01);
    rd(RP, d);
    check("toggle down", d, 32'h00);
    wr(RC, 8'h08);
    wr(RD, 8'h00);
    wr(RS, 8'hc0);
    settle();
    u_usw_peer.pulses(8);
    settle();
    rd(RD, d);
    check("ext shift", d, 32'hff);
    rd(RS, d);
    check("ext count", d, 32'hc0);
    wr(RC, 8'h04);
    wr(RS, 8'hc0);
    @(posedge clk);
    tmatch <= 1'b1;
    @(posedge clk);
    tmatch <= 1'b0;
    settle();
    rd(RS, d);
    check("timer count", d, 32'h01);
  endtask
  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h0;
    pwdata = 32'h0;
    tmatch = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_mode0();
    t_three();
    t_fifo();
    t_irq();
    t_two();
    t_hold();
    t_clocks();
    close_out();
  end
endmodule
